/* core/old_pwm.sv */
`timescale 1ns/100ps
module old_pwm (
  input  wire logic       sys_clk, // system clock
  input  wire logic       rst_n,   // sync reset
  input  wire logic       clk_en,  // clock enable
  input  wire logic [9:0] mag,     // duty magnitude, full scale = 100 %
  input  wire logic       neg,     // duty sign
  input  wire logic       invert,  // swap motor direction
  output logic            drv_a,   // bridge side a
  output logic            drv_b    // bridge side b
);
  import old_pkg::*;

  logic [9:0] cnt;
  // a full-scale magnitude keeps the compare true for the whole period
  wire        on  = (cnt < mag);
  wire        fwd = (neg == invert);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt   <= 10'h000;
      drv_a <= 1'b0;
      drv_b <= 1'b0;
    end else if (clk_en) begin
      cnt   <= (cnt == PWM_LAST) ? 10'h000 : cnt + 10'h001;
      drv_a <= on & fwd;
      drv_b <= on & ~fwd;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_excl;
    !(drv_a && drv_b);
  endproperty
  a_excl: assert property (p_excl) else $error("both bridge sides driven");

  property p_dir;
    clk_en && mag != 10'h000 && cnt == 10'h000 && neg == invert |=> drv_a && !drv_b;
  endproperty
  a_dir: assert property (p_dir) else $error("wrong side for direction");

  property p_full;
    clk_en && mag == FULL_SCALE && neg != invert |=> drv_b;
  endproperty
  a_full: assert property (p_full) else $error("full scale not continuous drive");

  property p_off;
    clk_en && mag == 10'h000 |=> !drv_a && !drv_b;
  endproperty
  a_off: assert property (p_off) else $error("drive with zero duty");
endmodule

/* core/old_tick.sv */
`timescale 1ns/100ps
module old_tick #(
  parameter int PERIOD_CYC = old_pkg::PID_PERIOD_CYC
) (
  input  wire logic sys_clk, // system clock
  input  wire logic rst_n,   // sync reset
  input  wire logic clk_en,  // clock enable
  output logic      tick     // one-cycle period pulse
);
  import old_pkg::*;

  localparam int CW = (PERIOD_CYC > 2) ? $clog2(PERIOD_CYC) : 1;

  logic [CW-1:0] cnt;
  wire           last = (cnt == CW'(PERIOD_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (clk_en) begin
      cnt  <= last ? '0 : cnt + 1'b1;
      tick <= last;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_tick_at_wrap;
    clk_en && last |=> tick;
  endproperty
  a_tick_at_wrap: assert property (p_tick_at_wrap) else $error("period tick missing at wrap");

  property p_tick_single;
    clk_en && tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("period tick longer than one cycle");
endmodule

/* core/old_top.sv */
`timescale 1ns/100ps
module old_top #(
  parameter int PERIOD_CYC = old_pkg::PID_PERIOD_CYC
) (
  input  wire logic              sys_clk,  // 25 MHz system clock
  input  wire logic              rst_n,    // sync reset, active low
  input  wire logic              clk_en,   // freezes all state while low
  input  wire logic [11:0]       target,   // target code, centre = stop
  input  wire old_pkg::old_cfg_t cfg,      // limits and error settings
  input  wire old_pkg::old_cmd_t cmd,      // run / stop command pulses
  input  wire logic              no_power, // missing motor power condition
  output old_pkg::old_stat_t     stat,     // registered status
  output logic                   drv_a,    // bridge side a
  output logic                   drv_b     // bridge side b
);
  import old_pkg::*;

  old_state_t state;
  old_state_t next_state;
  old_stat_t  next_stat;
  logic       tick;

  // error handling
  wire fault_cond = cfg.nopwr_en & no_power;
  wire latch_set  = fault_cond & cfg.nopwr_latch;
  // set wins over the run-command clear
  wire next_latch = latch_set | (stat.err_latched & ~cmd.run);
  wire halt_fault = fault_cond | next_latch;

  always_comb begin
    next_state = state;
    case (state)
      ST_STOPPED: begin
        if (cmd.run) begin
          next_state = halt_fault ? ST_FAULT : ST_RUN;
        end
      end
      ST_RUN: begin
        if (halt_fault) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // a latched error stays in next_latch until run clears it
        if (!halt_fault) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_STOPPED;
      end
    endcase
    if (cmd.stop) begin
      next_state = ST_STOPPED;
    end
  end

  wire halt = (next_state != ST_RUN);

  // target path
  wire logic signed [12:0] next_dc_target = $signed({1'b0, target}) - $signed({1'b0, CENTER_CODE});
  wire logic               tneg           = next_dc_target[12];
  wire logic [12:0]        tmag           = tneg ? 13'(13'h0000 - next_dc_target) : next_dc_target;
  wire logic [9:0]         lim            = old_min10(cfg.max_duty, FULL_SCALE);
  wire logic [9:0]         cm             = (tmag > {3'h0, lim}) ? lim : tmag[9:0];

  // ramp toward the clamped target
  wire logic [9:0] cur      = old_mag11(stat.duty);
  wire logic       cneg     = stat.duty[10];
  // a sign reversal decelerates to zero first and never crosses in one period
  wire logic       opposite = (cur != 10'h000) & (cm != 10'h000) & (cneg != tneg);
  wire logic       grow     = ~opposite & (cm > cur);
  wire logic [9:0] up_step  = old_min10(cfg.max_accel, cm - cur);
  wire logic [9:0] dn_step  = old_min10(cfg.max_decel, opposite ? cur : cur - cm);
  wire logic [9:0] ramp_mag = grow ? cur + up_step : cur - dn_step;
  // lowering the maximum takes effect at the next period tick, ahead of the deceleration limit
  wire logic [9:0] new_mag  = old_min10(ramp_mag, lim);
  wire logic       new_neg  = grow ? tneg : cneg;
  wire logic [10:0] mag_ext = {1'b0, new_mag};
  wire logic [10:0] ramp_duty = new_neg ? 11'h000 - mag_ext : mag_ext;

  wire logic [10:0] next_duty = halt ? 11'h000 : tick ? ramp_duty : stat.duty;
  wire logic [10:0] cm_ext    = {1'b0, cm};
  wire logic [10:0] lim_duty  = tneg ? 11'h000 - cm_ext : cm_ext;

  always_comb begin
    next_stat             = stat;
    next_stat.dc_target   = next_dc_target;
    next_stat.duty        = $signed(next_duty);
    next_stat.stopped     = halt;
    next_stat.err_latched = next_latch;
    next_stat.fault       = fault_cond;
    // shows that motor limits hold the duty away from its target
    next_stat.limited     = (next_duty != lim_duty) || (cm != tmag[9:0]) || (tmag > {3'h0, FULL_SCALE});
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_STOPPED;
      stat  <= STAT_RST;
    end else if (clk_en) begin
      state <= next_state;
      stat  <= next_stat;
    end
  end

  old_tick #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .tick    (tick)
  );

  old_pwm u_pwm (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .mag     (cur),
    .neg     (cneg),
    .invert  (cfg.invert),
    .drv_a   (drv_a),
    .drv_b   (drv_b)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  wire logic [10:0] mag_w = {1'b0, cur};

  property p_dct;
    clk_en |=> stat.dc_target == $signed({1'b0, $past(target)}) - 13'sh0800;
  endproperty
  a_dct: assert property (p_dct) else $error("duty target not target minus centre");

  property p_center;
    clk_en && target == CENTER_CODE && stat.duty == 11'sh000 |=> stat.duty == 11'sh000;
  endproperty
  a_center: assert property (p_center) else $error("centre target moved the motor");

  property p_range;
    cur <= FULL_SCALE;
  endproperty
  a_range: assert property (p_range) else $error("duty beyond full scale");

  property p_maxduty;
    clk_en && tick |=> cur <= $past(lim);
  endproperty
  a_maxduty: assert property (p_maxduty) else $error("duty above maximum");

  property p_accel;
    clk_en && tick |=> mag_w <= $past(mag_w) + {1'b0, $past(cfg.max_accel)};
  endproperty
  a_accel: assert property (p_accel) else $error("acceleration limit exceeded");

  property p_decel;
    clk_en && tick && !halt |=>
      (mag_w + {1'b0, $past(cfg.max_decel)} >= $past(mag_w)) || (cur == $past(lim));
  endproperty
  a_decel: assert property (p_decel) else $error("deceleration limit exceeded");

  property p_latch_set;
    clk_en && latch_set |=> stat.err_latched && stat.duty == 11'sh000;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latched error not stopping");

  property p_latch_hold;
    clk_en && stat.err_latched && !cmd.run |=> stat.err_latched && stat.duty == 11'sh000;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched error dropped without run");

  property p_run_clear;
    clk_en && cmd.run && !fault_cond |=> !stat.err_latched;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run did not clear latch");

  property p_stop;
    clk_en && cmd.stop ##1 (clk_en && !cmd.run)[*3] |=> stat.duty == 11'sh000 && stat.stopped;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not hold motor");

  property p_stop_now;
    clk_en && cmd.stop |=> stat.duty == 11'sh000;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("stop not immediate");

  property p_between;
    clk_en && !tick && !halt |=> stat.duty == $past(stat.duty);
  endproperty
  a_between: assert property (p_between) else $error("duty changed between periods");

  property p_fault;
    clk_en && fault_cond |=> stat.duty == 11'sh000 && stat.fault;
  endproperty
  a_fault: assert property (p_fault) else $error("duty nonzero under error");

  property p_sign;
    clk_en && tick && !halt && opposite |=> cur == 10'h000 || stat.duty[10] == $past(cneg);
  endproperty
  a_sign: assert property (p_sign) else $error("reversal crossed zero in one period");

  property p_stopped_duty;
    stat.stopped |-> stat.duty == 11'sh000;
  endproperty
  a_stopped_duty: assert property (p_stopped_duty) else $error("duty nonzero while stopped");

  property p_fault_flag;
    clk_en |=> stat.fault == ($past(cfg.nopwr_en) && $past(no_power));
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("error flag not following enabled condition");

  property p_fault_stop;
    stat.fault |-> stat.stopped;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("motor running under active error");

  property p_no_en;
    clk_en && !cfg.nopwr_en |=> !stat.fault;
  endproperty
  a_no_en: assert property (p_no_en) else $error("disabled error still reported");

  property p_unlatched;
    clk_en && !cfg.nopwr_latch && !stat.err_latched |=> !stat.err_latched;
  endproperty
  a_unlatched: assert property (p_unlatched) else $error("latch set while latching disabled");

  property p_latch_gate;
    clk_en && !cfg.nopwr_en |=> stat.err_latched == ($past(stat.err_latched) && !$past(cmd.run));
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("latch changed without set or run");

  property p_run_start;
    clk_en && cmd.run && !cmd.stop && !fault_cond |=> !stat.stopped;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run without error left motor stopped");

  property p_run_fault;
    clk_en && cmd.run && fault_cond |=> stat.stopped && stat.duty == 11'sh000;
  endproperty
  a_run_fault: assert property (p_run_fault) else $error("run started motor under active error");

  property p_resume;
    clk_en && state == ST_FAULT && !halt_fault && !cmd.stop |=> !stat.stopped;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after error cleared");

  property p_stop_state;
    clk_en && cmd.stop |=> state == ST_STOPPED;
  endproperty
  a_stop_state: assert property (p_stop_state) else $error("stop did not enter stopped state");

  property p_halt_zero;
    clk_en && halt |=> stat.duty == 11'sh000 && stat.stopped;
  endproperty
  a_halt_zero: assert property (p_halt_zero) else $error("halt did not zero duty");

  property p_dc_center;
    clk_en && target == CENTER_CODE |=> stat.dc_target == 13'sh0000;
  endproperty
  a_dc_center: assert property (p_dc_center) else $error("centre target gave nonzero duty target");

  property p_clamped;
    clk_en && cm != tmag[9:0] |=> stat.limited;
  endproperty
  a_clamped: assert property (p_clamped) else $error("clamped target not flagged as limited");

  property p_reach;
    clk_en && tick && !halt && !opposite && cm >= cur && cm - cur <= cfg.max_accel |=>
      cur == $past(cm);
  endproperty
  a_reach: assert property (p_reach) else $error("reachable target not reached in one period");

  property p_accel_full;
    clk_en && tick && !halt && !opposite && cm > cur && cm - cur > cfg.max_accel |=>
      mag_w == $past(mag_w) + {1'b0, $past(cfg.max_accel)};
  endproperty
  a_accel_full: assert property (p_accel_full) else $error("acceleration step not taken in full");

  property p_decel_full;
    clk_en && tick && !halt && !opposite && cm < cur && cur - cm > cfg.max_decel && cur <= lim |=>
      mag_w + {1'b0, $past(cfg.max_decel)} == $past(mag_w);
  endproperty
  a_decel_full: assert property (p_decel_full) else $error("deceleration step not taken in full");

  property p_new_sign;
    clk_en && tick && !halt && cur == 10'h000 |=>
      cur == 10'h000 || stat.duty[10] == $past(tneg);
  endproperty
  a_new_sign: assert property (p_new_sign) else $error("start from zero in wrong direction");

  property p_freeze;
    !clk_en |=> $stable(stat) && state == $past(state);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_freeze_drv;
    !clk_en |=> $stable(drv_a) && $stable(drv_b);
  endproperty
  a_freeze_drv: assert property (p_freeze_drv) else $error("drive moved while clock enable low");

  c_full: cover property (cur == FULL_SCALE);
  c_resume: cover property (state == ST_FAULT ##1 state == ST_RUN);
  c_reverse: cover property (stat.duty[10] ##[1:1000] (!stat.duty[10] && cur != 10'h000));
  c_latch_run: cover property (stat.err_latched ##1 !stat.err_latched ##1 state == ST_RUN);
  c_limited: cover property (stat.limited && cur != 10'h000);
endmodule

/* shared/old_pkg.sv */
// Summary of operation
// - Duty-cycle target equals target minus centre code; centre code means motor stopped.
// - Duty magnitude of full scale is 100 percent drive, smaller values proportional.
// - Applied duty magnitude is clamped to the configured maximum duty cycle.
// - Per PID period, duty magnitude rises by at most the acceleration limit.
// - Per PID period, duty magnitude falls by at most the deceleration limit; a lowered maximum duty, a stop or an error halt cuts it further.
// - Latched missing-power error stops the motor and holds until a run command.
// - Run command clears all latched errors; active conditions still keep the motor stopped.
// - Stop command is accepted any time and halts drive immediately.
// - Applied duty is readable, separate from the target, and reflects the limits.
// - Inversion setting swaps which output polarity a positive duty drives.
// - Control update with limits runs once per PID period, default ten milliseconds.
// - Drive direction follows the sign of the applied duty and the inversion setting.
package old_pkg;

  localparam int CLK_HZ         = 25_000_000;
  localparam int PID_PERIOD_MS  = 10;
  // never longer than nominal: integer division rounds down
  localparam int PID_PERIOD_CYC = (CLK_HZ / 1000) * PID_PERIOD_MS;

  localparam logic [11:0] CENTER_CODE = 12'h800;
  localparam logic [9:0]  FULL_SCALE  = 10'h258;
  localparam logic [9:0]  PWM_LAST    = 10'h257;

  typedef struct packed {
    logic [9:0] max_duty;
    logic [9:0] max_accel;
    logic [9:0] max_decel;
    logic       invert;
    logic       nopwr_en;
    logic       nopwr_latch;
  } old_cfg_t;

  typedef struct packed {
    logic run;
    logic stop;
  } old_cmd_t;

  typedef struct packed {
    logic signed [12:0] dc_target;
    logic signed [10:0] duty;
    logic               stopped;
    logic               err_latched;
    logic               fault;
    logic               limited;
  } old_stat_t;

  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_RUN     = 3'b010,
    ST_FAULT   = 3'b100
  } old_state_t;

  localparam old_stat_t STAT_RST = '{
    dc_target:   13'h0000,
    duty:        11'h000,
    stopped:     1'b1,
    err_latched: 1'b0,
    fault:       1'b0,
    limited:     1'b0
  };

  function automatic logic [9:0] old_min10(input logic [9:0] a, input logic [9:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [9:0] old_mag11(input logic [10:0] d);
    return d[10] ? 10'(11'h000 - d) : d[9:0];
  endfunction

endpackage

/* tb/old_host.sv */
`timescale 1ns/100ps
module old_host (
  input  wire logic          sys_clk,  // system clock
  output logic [11:0]        target,   // target code, centre = stop
  output old_pkg::old_cfg_t  cfg,      // limits and error settings
  output old_pkg::old_cmd_t  cmd,      // run / stop pulses
  output logic               no_power  // missing motor power condition
);
  import old_pkg::*;

  initial begin
    target   = CENTER_CODE;
    cfg      = '0;
    cmd      = '0;
    no_power = 1'b0;
  end

  // settings change just after an edge and then stay put, as host software would leave them
  task automatic set_all(input logic [11:0] t, input old_cfg_t c);
    @(posedge sys_clk);
    target <= t;
    cfg    <= c;
  endtask

  // one enabled cycle only: a longer pulse would be taken again on every edge
  task automatic pulse(input logic run, input logic stop, input logic pwr);
    @(posedge sys_clk);
    cmd      <= '{run: run, stop: stop};
    no_power <= pwr;
    @(posedge sys_clk);
    cmd      <= '0;
    no_power <= 1'b0;
  endtask
endmodule

/* tb/old_top_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module old_top_tb;
  import old_pkg::*;
  localparam int P = 20;
  logic        sys_clk;
  logic        rst_n;
  logic        clk_en;
  logic        no_power;
  logic        drv_a;
  logic        drv_b;
  logic [11:0] target;
  old_cfg_t    c;
  old_cfg_t    cfg;
  old_cmd_t    cmd;
  old_stat_t   stat;
  int          n_fail;
  int          compares;
  int          cyc;
  int          na;
  int          nb;

  old_host u_host (
    .sys_clk  (sys_clk),
    .target   (target),
    .cfg      (cfg),
    .cmd      (cmd),
    .no_power (no_power)
  );

  old_top #(.PERIOD_CYC(P)) uut (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .target   (target),
    .cfg      (cfg),
    .cmd      (cmd),
    .no_power (no_power),
    .stat     (stat),
    .drv_a    (drv_a),
    .drv_b    (drv_b)
  );

  task automatic stop_test;
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // the ramp only moves on period ticks, so wait at most two periods plus four cycles for it
  task automatic wait_duty;
    logic signed [10:0] d;
    int i;
    d = stat.duty;
    for (i = 0; i < 2 * P + 4 && stat.duty === d; i++)
      @(negedge sys_clk);
    if (stat.duty === d) begin
      n_fail++;
      stop_test;
    end
  endtask

  // any 600 consecutive cycles hold exactly |duty| high cycles on one side
  task automatic count_drv(input int ea, input int eb);
    na = 0;
    nb = 0;
    repeat (3) @(negedge sys_clk);
    repeat (600) begin
      @(negedge sys_clk);
      na += drv_a;
      nb += drv_b;
    end
    `CHK(na, ea)
    `CHK(nb, eb)
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end

  initial begin
    rst_n  = 1'b0;
    clk_en = 1'b1;
    c = '{max_duty: 10'h0c8, max_accel: 10'h006, max_decel: FULL_SCALE,
          invert: 1'b0, nopwr_en: 1'b0, nopwr_latch: 1'b0};
    u_host.set_all(12'h864, c);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    `CHK(stat, STAT_RST)
    u_host.pulse(1'b1, 1'b0, 1'b0);
    @(negedge sys_clk);
    `CHK(stat.stopped, 1'b0)
    `CHK(stat.dc_target, 13'h0064)
    wait_duty;
    `CHK(stat.duty, 11'h006)
    `CHK(stat.limited, 1'b1)
    wait_duty;
    `CHK(stat.duty, 11'h00c)
    c.max_accel = FULL_SCALE;
    u_host.set_all(12'ha58, c);
    wait_duty;
    `CHK(stat.duty, 11'h0c8)
    count_drv(200, 0);
    c.invert = 1'b1;
    u_host.set_all(12'ha58, c);
    count_drv(0, 200);
    c.invert    = 1'b0;
    c.max_decel = 10'h032;
    u_host.set_all(CENTER_CODE, c);
    wait_duty;
    `CHK(stat.duty, 11'h096)
    c.max_decel = FULL_SCALE;
    u_host.set_all(12'h79c, c);
    wait_duty;
    `CHK(stat.duty, 11'h000)
    wait_duty;
    `CHK(stat.duty, 11'h79c)
    `CHK(stat.limited, 1'b0)
    @(posedge sys_clk);
    clk_en <= 1'b0;
    u_host.set_all(12'h864, c);
    repeat (2 * P) @(negedge sys_clk);
    `CHK(stat.duty, 11'h79c)
    `CHK(stat.dc_target, 13'h1f9c)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    u_host.pulse(1'b0, 1'b1, 1'b0);
    @(negedge sys_clk);
    `CHK(stat.duty, 11'h000)
    `CHK(stat.stopped, 1'b1)
    c.nopwr_en    = 1'b1;
    c.nopwr_latch = 1'b1;
    u_host.set_all(12'h79c, c);
    u_host.pulse(1'b1, 1'b0, 1'b0);
    @(negedge sys_clk);
    `CHK(stat.stopped, 1'b0)
    u_host.pulse(1'b0, 1'b0, 1'b1);
    @(negedge sys_clk);
    `CHK(stat.err_latched, 1'b1)
    `CHK(stat.duty, 11'h000)
    `CHK(stat.fault, 1'b1)
    repeat (2 * P) @(negedge sys_clk);
    `CHK(stat.err_latched, 1'b1)
    `CHK(stat.stopped, 1'b1)
    `CHK(stat.fault, 1'b0)
    u_host.pulse(1'b1, 1'b0, 1'b0);
    @(negedge sys_clk);
    `CHK(stat.err_latched, 1'b0)
    `CHK(stat.stopped, 1'b0)
    stop_test;
  end
endmodule
